// ---- logic/dlc_defs.svh ----
`ifndef DLC_DEFS_SVH
`define DLC_DEFS_SVH

// ----------------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------------
// Width of the byte address seen on the register bus.
`define DLC_AW 8
// Byte address of the data lane common configuration register.
`define DLC_ADR_LANE_CFG 8'h00
// Byte address of the DRAM system configuration register.
`define DLC_ADR_DRAM_CFG 8'h04
// Byte address of the calibration trigger register.
`define DLC_ADR_CAL_CTRL 8'h08

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DLC_LCC_TERM 0
`define DLC_LCC_IOM 1
`define DLC_LCC_MDL 2
`define DLC_LCC_PDD 3
`define DLC_LCC_PDR 4
`define DLC_LCC_RES_LO 5
`define DLC_LCC_RES_HI 8
`define DLC_RES_W 4
`define DLC_DCR_SINGLE_RANK_ACCESS_ONLY 27
`define DLC_DCR_MIRROR 29
`define DLC_CAL_GO 0

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define DLC_RST_STROBE_RES 4'h4
`define DLC_RST_MDL 1'b1
`define DLC_RST_OFF 1'b0
`define DLC_MAX_LANES 32

`endif

// ---- logic/dlc_pkg.sv ----
`include "dlc_defs.svh"

// ----------------------------------------------------------------------------
// Types shared by the configuration block and its lane controllers
// ----------------------------------------------------------------------------
package dlc_pkg;

    // Whole state of the register block.
    typedef struct packed {
        logic ack;                          // Bus acknowledge.
        logic [31:0] rdata;                 // Registered read data.
        logic [`DLC_RES_W-1:0] strobe_res;  // Strobe resistor select.
        logic res_open;                     // Strobe resistor disconnected.
        logic rx_pd;                        // Global receiver power-down.
        logic drv_pd;                       // Global driver power-down.
        logic recal_en;                     // Global delay line recalibration.
        logic io_mode;                      // Global I/O mode, 1 is CMOS.
        logic term_en;                      // Global termination enable.
        logic addr_mirror;                  // Address mirroring on rank two.
        logic single_rank;                  // One chip select at a time.
        logic cal_start;                    // Calibration start pulse.
        logic init_done;                    // Reset calibration issued.
    } dlc_state_t;

    // Whole state of one lane controller.
    typedef struct packed {
        logic rx_pd;                        // Effective receiver power-down.
        logic drv_pd;                       // Effective driver power-down.
        logic recal_en;                     // Effective recalibration enable.
        logic io_mode;                      // Effective I/O mode.
        logic term_en;                      // Effective termination enable.
    } dlc_lane_t;

endpackage : dlc_pkg

// ---- logic/dlc_lane_ctrl.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Lane controller: merges global and local control of one byte lane
// ----------------------------------------------------------------------------
module dlc_lane_ctrl
    import dlc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic glb_rx_pd_i,
    input wire logic glb_drv_pd_i,
    input wire logic glb_recal_en_i,
    input wire logic glb_io_mode_i,
    input wire logic glb_term_en_i,
    input wire logic loc_rx_pd_i,
    input wire logic loc_drv_pd_i,
    input wire logic loc_recal_en_i,
    input wire logic loc_io_mode_i,
    input wire logic loc_term_en_i,
    output logic rx_pd_o,
    output logic drv_pd_o,
    output logic recal_en_o,
    output logic io_mode_o,
    output logic term_en_o
);

    dlc_lane_t st_reg;   // Registered lane controls.
    dlc_lane_t st_next;  // Next lane controls.

    // Power-down, mode and termination are forced by either side; the
    // recalibration needs both sides to agree.
    always_comb
    begin
        st_next = st_reg;
        st_next.rx_pd = glb_rx_pd_i | loc_rx_pd_i;
        st_next.drv_pd = glb_drv_pd_i | loc_drv_pd_i;
        st_next.recal_en = glb_recal_en_i & loc_recal_en_i;
        st_next.io_mode = glb_io_mode_i | loc_io_mode_i;
        st_next.term_en = glb_term_en_i | loc_term_en_i;
    end

    // Registers the merged controls so the lane sees clean levels.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rx_pd_o = st_reg.rx_pd;
    assign drv_pd_o = st_reg.drv_pd;
    assign recal_en_o = st_reg.recal_en;
    assign io_mode_o = st_reg.io_mode;
    assign term_en_o = st_reg.term_en;

endmodule : dlc_lane_ctrl

// ---- logic/dlc_config_top.sv ----
`timescale 1ns/1ns
`include "dlc_defs.svh"

// Function
// - Strobe resistor resets 0x4; top bit selects pull-up.
// - Low three bits pick resistor; zero means open.
// - Receiver power-down is global OR lane bit.
// - Driver power-down is global OR lane bit.
// - Delay line enable resets high; calibration restarts.
// - Lane recalibration is global AND lane bit.
// - I/O mode is global OR lane; 1 CMOS.
// - Termination enable is global OR lane bit.
// - Mirroring bit enables second rank address mirroring.
// - Single rank bit forbids simultaneous chip selects.

module dlc_config_top
    import dlc_pkg::*;
#(
    parameter int NUM_LANES = 4  // Number of data byte lanes served.
)
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [`DLC_AW-1:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic [NUM_LANES-1:0] LANE_RX_PD_I,
    input wire logic [NUM_LANES-1:0] LANE_DRV_PD_I,
    input wire logic [NUM_LANES-1:0] LANE_RECAL_EN_I,
    input wire logic [NUM_LANES-1:0] LANE_IO_MODE_I,
    input wire logic [NUM_LANES-1:0] LANE_TERM_EN_I,
    output logic [NUM_LANES-1:0] LANE_RX_PD_O,
    output logic [NUM_LANES-1:0] LANE_DRV_PD_O,
    output logic [NUM_LANES-1:0] LANE_RECAL_EN_O,
    output logic [NUM_LANES-1:0] LANE_IO_MODE_O,
    output logic [NUM_LANES-1:0] LANE_TERM_EN_O,
    output logic DQS_PULL_UP_O,
    output logic [2:0] DQS_RES_CODE_O,
    output logic DQS_RES_OPEN_O,
    output logic MDL_CAL_START_O,
    output logic ADDR_MIRROR_O,
    output logic SINGLE_RANK_O
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------

    // The lane vectors must hold at least one lane and stay within the limit.
    generate
        if (NUM_LANES < 1 || NUM_LANES > `DLC_MAX_LANES)
        begin : g_bad_lanes
            $error("NUM_LANES is out of range.");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // State and bus qualifiers
    // ------------------------------------------------------------------------

    dlc_state_t st_reg;   // Registered block state.
    dlc_state_t st_next;  // Next block state.
    logic bus_req;        // A bus cycle is presented.
    logic bus_wr;         // A write is completing at this edge.
    logic [31:0] lane_word;  // Read image of the lane configuration.
    logic [31:0] dram_word;  // Read image of the DRAM configuration.

    // A request is live while both cycle and strobe are high.
    assign bus_req = CYC_I && STB_I;

    // A write takes effect only at the edge where the master sees ack.
    assign bus_wr = bus_req && WE_I && st_reg.ack;

    // ------------------------------------------------------------------------
    // Read images
    // ------------------------------------------------------------------------

    // Builds the lane configuration word; unused positions stay zero.
    always_comb
    begin
        lane_word = 32'h0;
        lane_word[`DLC_LCC_RES_HI:`DLC_LCC_RES_LO] = st_reg.strobe_res;
        lane_word[`DLC_LCC_PDR] = st_reg.rx_pd;
        lane_word[`DLC_LCC_PDD] = st_reg.drv_pd;
        lane_word[`DLC_LCC_MDL] = st_reg.recal_en;
        lane_word[`DLC_LCC_IOM] = st_reg.io_mode;
        lane_word[`DLC_LCC_TERM] = st_reg.term_en;
    end

    // Builds the DRAM configuration word; unused positions stay zero.
    always_comb
    begin
        dram_word = 32'h0;
        dram_word[`DLC_DCR_MIRROR] = st_reg.addr_mirror;
        dram_word[`DLC_DCR_SINGLE_RANK_ACCESS_ONLY] = st_reg.single_rank;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------

    // Answers each request one cycle after it appears, applies writes at
    // the acknowledge edge and produces the calibration start pulse.
    always_comb
    begin
        st_next = st_reg;

        // The start pulse lasts one cycle unless raised again below.
        st_next.cal_start = 1'b0;

        // The first cycle after reset starts the initial measurements.
        st_next.init_done = 1'b1;
        if (!st_reg.init_done)
        begin
            st_next.cal_start = 1'b1;
        end

        // Ack rises for one cycle and then drops even if the request stays.
        st_next.ack = bus_req && !st_reg.ack;

        // Read data is captured with the acknowledge; other times it is zero.
        st_next.rdata = 32'h0;
        if (bus_req && !st_reg.ack && !WE_I)
        begin
            // Picks the register by its full byte address.
            if (ADR_I == `DLC_ADR_LANE_CFG)
            begin
                st_next.rdata = lane_word;
            end
            else if (ADR_I == `DLC_ADR_DRAM_CFG)
            begin
                st_next.rdata = dram_word;
            end
            else
            begin
                // The trigger register and unmapped addresses read zero.
                st_next.rdata = 32'h0;
            end
        end

        // Writes honour the byte lanes; other bits are simply not stored.
        if (bus_wr)
        begin
            if (ADR_I == `DLC_ADR_LANE_CFG)
            begin
                // Byte lane zero holds the global switches and the low
                // three bits of the resistor select.
                if (SEL_I[0])
                begin
                    st_next.strobe_res[2:0] = DAT_I[`DLC_LCC_RES_HI-1:`DLC_LCC_RES_LO];
                    st_next.rx_pd = DAT_I[`DLC_LCC_PDR];
                    st_next.drv_pd = DAT_I[`DLC_LCC_PDD];
                    st_next.recal_en = DAT_I[`DLC_LCC_MDL];
                    st_next.io_mode = DAT_I[`DLC_LCC_IOM];
                    st_next.term_en = DAT_I[`DLC_LCC_TERM];
                end
                // Byte lane one holds the pull direction bit.
                if (SEL_I[1])
                begin
                    st_next.strobe_res[3] = DAT_I[`DLC_LCC_RES_HI];
                end
            end
            else if (ADR_I == `DLC_ADR_DRAM_CFG)
            begin
                // Both DRAM bits sit in the top byte lane.
                if (SEL_I[3])
                begin
                    st_next.addr_mirror = DAT_I[`DLC_DCR_MIRROR];
                    st_next.single_rank = DAT_I[`DLC_DCR_SINGLE_RANK_ACCESS_ONLY];
                end
            end
            else if (ADR_I == `DLC_ADR_CAL_CTRL)
            begin
                // Writing one restarts the initial period measurements.
                if (SEL_I[0] && DAT_I[`DLC_CAL_GO])
                begin
                    st_next.cal_start = 1'b1;
                end
            end
            else
            begin
                // Unmapped addresses are acknowledged and ignored.
                st_next.cal_start = st_next.cal_start;
            end
        end

        // The open flag follows the value code that will be stored.
        st_next.res_open = (st_next.strobe_res[2:0] == 3'h0);
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------

    // Holds the whole block state; reset gives the documented defaults.
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            st_reg <= '0;
            st_reg.strobe_res <= `DLC_RST_STROBE_RES;
            st_reg.recal_en <= `DLC_RST_MDL;
            st_reg.rx_pd <= `DLC_RST_OFF;
            st_reg.drv_pd <= `DLC_RST_OFF;
            st_reg.io_mode <= `DLC_RST_OFF;
            st_reg.term_en <= `DLC_RST_OFF;
            st_reg.addr_mirror <= `DLC_RST_OFF;
            st_reg.single_rank <= `DLC_RST_OFF;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------------
    // Lane controllers
    // ------------------------------------------------------------------------

    // One controller per byte lane merges the global and local bits.
    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g = g + 1)
        begin : g_lane
            dlc_lane_ctrl u_lane (
                .clk_i(CLK_I),
                .rst_b_i(RST_B_I),
                .glb_rx_pd_i(st_reg.rx_pd),
                .glb_drv_pd_i(st_reg.drv_pd),
                .glb_recal_en_i(st_reg.recal_en),
                .glb_io_mode_i(st_reg.io_mode),
                .glb_term_en_i(st_reg.term_en),
                .loc_rx_pd_i(LANE_RX_PD_I[g]),
                .loc_drv_pd_i(LANE_DRV_PD_I[g]),
                .loc_recal_en_i(LANE_RECAL_EN_I[g]),
                .loc_io_mode_i(LANE_IO_MODE_I[g]),
                .loc_term_en_i(LANE_TERM_EN_I[g]),
                .rx_pd_o(LANE_RX_PD_O[g]),
                .drv_pd_o(LANE_DRV_PD_O[g]),
                .recal_en_o(LANE_RECAL_EN_O[g]),
                .io_mode_o(LANE_IO_MODE_O[g]),
                .term_en_o(LANE_TERM_EN_O[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    // Every output assigned here is a field of the state register; the lane vectors come from the lane controllers.
    assign DAT_O = st_reg.rdata;
    assign ACK_O = st_reg.ack;
    assign DQS_PULL_UP_O = st_reg.strobe_res[3];
    assign DQS_RES_CODE_O = st_reg.strobe_res[2:0];
    assign DQS_RES_OPEN_O = st_reg.res_open;
    assign MDL_CAL_START_O = st_reg.cal_start;
    assign ADDR_MIRROR_O = st_reg.addr_mirror;
    assign SINGLE_RANK_O = st_reg.single_rank;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------

    default clocking cb_main @(posedge CLK_I);
    endclocking

    default disable iff (!RST_B_I);

    // Ack is a single-cycle answer.
    a_ack_one_cycle: assert property (ACK_O |=> !ACK_O)
        else $error("Ack stayed high for two cycles.");

    // A new request is answered on the next edge.
    a_ack_latency: assert property (bus_req && !ACK_O |=> ACK_O)
        else $error("Request was not answered in one cycle.");

    // A full write of the lane word loads the resistor field.
    a_strobe_write: assert property (
        bus_req && WE_I && ACK_O && ADR_I == `DLC_ADR_LANE_CFG && SEL_I[1:0] == 2'h3
        |=> {DQS_PULL_UP_O, DQS_RES_CODE_O} == $past(DAT_I[`DLC_LCC_RES_HI:`DLC_LCC_RES_LO]))
        else $error("Strobe resistor field did not follow the write.");

    // The open flag marks exactly the zero value code.
    a_res_open_flag: assert property (DQS_RES_OPEN_O == (DQS_RES_CODE_O == 3'h0))
        else $error("Resistor open flag disagrees with the code.");

    // Lane zero receiver power-down is the OR of both sources.
    a_rx_pd_merge: assert property (
        $past(RST_B_I) |-> LANE_RX_PD_O[0] == ($past(st_reg.rx_pd) | $past(LANE_RX_PD_I[0])))
        else $error("Receiver power-down merge is wrong.");

    // Lane zero driver power-down is the OR of both sources.
    a_drv_pd_merge: assert property (
        $past(RST_B_I) |-> LANE_DRV_PD_O[0] == ($past(st_reg.drv_pd) | $past(LANE_DRV_PD_I[0])))
        else $error("Driver power-down merge is wrong.");

    // A trigger write starts calibration on the next cycle.
    a_cal_trigger: assert property (
        bus_wr && ADR_I == `DLC_ADR_CAL_CTRL && SEL_I[0] && DAT_I[`DLC_CAL_GO]
        |=> MDL_CAL_START_O)
        else $error("Calibration trigger produced no start pulse.");

    // Lane zero recalibration needs both enables.
    a_recal_merge: assert property (
        $past(RST_B_I) |-> LANE_RECAL_EN_O[0] == ($past(st_reg.recal_en) & $past(LANE_RECAL_EN_I[0])))
        else $error("Recalibration enable merge is wrong.");

    // Lane zero I/O mode is the OR of both sources.
    a_io_mode_merge: assert property (
        $past(RST_B_I) |-> LANE_IO_MODE_O[0] == ($past(st_reg.io_mode) | $past(LANE_IO_MODE_I[0])))
        else $error("I/O mode merge is wrong.");

    // Lane zero termination is the OR of both sources.
    a_term_merge: assert property (
        $past(RST_B_I) |-> LANE_TERM_EN_O[0] == ($past(st_reg.term_en) | $past(LANE_TERM_EN_I[0])))
        else $error("Termination merge is wrong.");

    // A top-lane write of the DRAM word loads the mirroring bit.
    a_mirror_write: assert property (
        bus_wr && ADR_I == `DLC_ADR_DRAM_CFG && SEL_I[3]
        |=> ADDR_MIRROR_O == $past(DAT_I[`DLC_DCR_MIRROR]))
        else $error("Mirroring bit did not follow the write.");

    // A top-lane write of the DRAM word loads the single rank bit.
    a_single_rank_write: assert property (
        bus_wr && ADR_I == `DLC_ADR_DRAM_CFG && SEL_I[3]
        |=> SINGLE_RANK_O == $past(DAT_I[`DLC_DCR_SINGLE_RANK_ACCESS_ONLY]))
        else $error("Single rank bit did not follow the write.");

    // Unused positions of the DRAM word read as zero.
    a_reserved_zero: assert property (
        ACK_O && !WE_I && bus_req && ADR_I == `DLC_ADR_DRAM_CFG
        |-> (DAT_O & ~(32'h1 << `DLC_DCR_MIRROR) & ~(32'h1 << `DLC_DCR_SINGLE_RANK_ACCESS_ONLY)) == 32'h0)
        else $error("Reserved DRAM bits read non-zero.");

endmodule : dlc_config_top

// ---- bench/dlc_config_top_tb.sv ----
`timescale 1ns/1ns
`include "dlc_defs.svh"

module dlc_config_top_tb;

    // ------------------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------------------
    logic clk = 1'b0;                 // 25 MHz register clock.
    logic rst_b = 1'b0;               // Active low reset.
    logic cyc = 1'b0;                 // Bus cycle.
    logic stb = 1'b0;                 // Bus strobe.
    logic we = 1'b0;                  // Bus write enable.
    logic [7:0] adr = 8'h00;          // Bus byte address.
    logic [3:0] sel = 4'h0;           // Bus byte enables.
    logic [31:0] dat = 32'h0;         // Bus write data.
    logic [31:0] dat_o;               // Bus read data.
    logic ack_o;                      // Bus acknowledge.
    logic [3:0] rx_i = 4'h0, drv_i = 4'h0, rec_i = 4'h0, iom_i = 4'h0, trm_i = 4'h0;
    logic [3:0] rx_o, drv_o, rec_o, iom_o, trm_o;
    logic pull_up_o, res_open_o, cal_o, mirror_o, single_o;
    logic [2:0] res_code_o;
    logic [31:0] rd;                  // Last word read.
    logic [31:0] gv;                  // Global bits under test.
    int num_errors = 0;               // Mismatches seen.
    int check_count = 0;              // Comparisons made.
    int cal_cnt = 0;                  // Calibration start pulses seen.

    dlc_config_top #(.NUM_LANES(4)) uut (
        .CLK_I(clk), .RST_B_I(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack_o),
        .LANE_RX_PD_I(rx_i), .LANE_DRV_PD_I(drv_i), .LANE_RECAL_EN_I(rec_i),
        .LANE_IO_MODE_I(iom_i), .LANE_TERM_EN_I(trm_i),
        .LANE_RX_PD_O(rx_o), .LANE_DRV_PD_O(drv_o), .LANE_RECAL_EN_O(rec_o),
        .LANE_IO_MODE_O(iom_o), .LANE_TERM_EN_O(trm_o),
        .DQS_PULL_UP_O(pull_up_o), .DQS_RES_CODE_O(res_code_o), .DQS_RES_OPEN_O(res_open_o),
        .MDL_CAL_START_O(cal_o), .ADDR_MIRROR_O(mirror_o), .SINGLE_RANK_O(single_o)
    );

    // The clock toggles every half period of 20 ns.
    always #20 clk = ~clk;

    // Counts one-cycle calibration start pulses while out of reset.
    always @(posedge clk)
    begin
        if (rst_b && cal_o === 1'b1)
        begin
            cal_cnt <= cal_cnt + 1;
        end
    end

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One classic Wishbone cycle; the request holds until ack is sampled.
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        // Waits as long as the slave needs; only the watchdog ends a hang.
        do
        begin
            @(posedge clk);
        end
        while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb_cycle

    // Writes a word with the given byte enables, then lets lane outputs settle.
    task automatic wb_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, s, q);
        repeat (3) @(posedge clk);
    endtask : wb_write

    // Reads a word.
    task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
        wb_cycle(1'b0, a, 32'h0, 4'hf, q);
    endtask : wb_read

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // A hang counts as a mismatch and ends the run the usual way.
    initial
    begin
        repeat (6000) @(posedge clk);
        num_errors++;
        close_out();
    end

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset values, one pulse after release, and unmapped space.
        check("cal after reset", cal_cnt, 1);
        wb_read(`DLC_ADR_LANE_CFG, rd);
        check("lane cfg reset", rd, 32'h0000_0084);
        wb_read(`DLC_ADR_DRAM_CFG, rd);
        check("dram cfg reset", rd, 32'h0);
        check("mirror reset", mirror_o, 32'h0);
        check("single reset", single_o, 32'h0);
        wb_read(8'h0c, rd);
        check("unmapped read", rd, 32'h0);
        $display("Test reset done");
        // Reserved bits read zero after an all-ones write.
        wb_write(`DLC_ADR_LANE_CFG, 32'hffff_ffff, 4'hf);
        wb_read(`DLC_ADR_LANE_CFG, rd);
        check("lane cfg ones", rd, 32'h0000_01ff);
        wb_write(`DLC_ADR_DRAM_CFG, 32'hffff_ffff, 4'hf);
        wb_read(`DLC_ADR_DRAM_CFG, rd);
        check("dram cfg ones", rd, 32'h2800_0000);
        // Mirroring is cleared independently of single rank access; single rank is then cleared alone, and both are set together.
        wb_write(`DLC_ADR_DRAM_CFG, 32'h0800_0000, 4'hf);
        check("mirror clear", mirror_o, 32'h0);
        check("single kept", single_o, 32'h1);
        wb_write(`DLC_ADR_DRAM_CFG, 32'h0, 4'hf);
        check("single clear", single_o, 32'h0);
        wb_write(`DLC_ADR_DRAM_CFG, 32'h2800_0000, 4'hf);
        check("mirror set", mirror_o, 32'h1);
        check("single set", single_o, 32'h1);
        $display("Test reserved and dram done");
        // Every strobe resistor code, with both pull directions.
        for (int k = 0; k < 16; k++)
        begin
            wb_write(`DLC_ADR_LANE_CFG, (k << 5) | 32'h4, 4'hf);
            check("pull up", pull_up_o, (k >> 3) & 1);
            check("res code", res_code_o, k & 7);
            check("res open", res_open_o, (k & 7) == 0);
        end
        // A write with only the upper enable touches bit 8 alone.
        wb_write(`DLC_ADR_LANE_CFG, 32'h0000_00ff, 4'h2);
        wb_read(`DLC_ADR_LANE_CFG, rd);
        check("byte enable", rd, 32'h0000_00e4);
        $display("Test strobe resistor done");
        // Global bits merged with distinct local patterns on each lane.
        rx_i <= 4'h5;
        drv_i <= 4'ha;
        rec_i <= 4'h3;
        iom_i <= 4'hc;
        trm_i <= 4'h9;
        for (int j = 0; j < 7; j++)
        begin
            gv = (j == 0) ? 32'h0 : (j == 1) ? 32'h1f : (32'h1 << (j - 2));
            wb_write(`DLC_ADR_LANE_CFG, 32'h80 | gv, 4'hf);
            check("rx pd", rx_o, gv[4] ? 4'hf : 4'h5);
            check("drv pd", drv_o, gv[3] ? 4'hf : 4'ha);
            check("recal", rec_o, gv[2] ? 4'h3 : 4'h0);
            check("io mode", iom_o, gv[1] ? 4'hf : 4'hc);
            check("term", trm_o, gv[0] ? 4'hf : 4'h9);
        end
        $display("Test lane merge done");
        // Calibration trigger: one pulse for a one, none for a zero.
        wb_write(`DLC_ADR_CAL_CTRL, 32'h1, 4'hf);
        check("cal trigger", cal_cnt, 2);
        wb_write(`DLC_ADR_CAL_CTRL, 32'h0, 4'hf);
        check("cal no trigger", cal_cnt, 2);
        wb_read(`DLC_ADR_CAL_CTRL, rd);
        check("cal reads zero", rd, 32'h0);
        $display("Test calibration done");
        close_out();
    end

endmodule : dlc_config_top_tb
